/* rtl/cnd_pkg.sv */
// Notes on behaviour
// RULE1: Immediate is sign-extended to 32 bits.
// RULE2: Write one if unequal, else zero.
// RULE3: Eight-bit selector picks custom function.
// RULE4: Result-write flag routes result to general register.
// RULE5: Operand-read flag one means general register.
// RULE6: Cleared flag addresses custom register file.
// RULE7: Two operands and three indices go out.
// RULE8: Opcodes 0x18 and 0x32 in low bits.
package cnd_pkg;
  localparam int XLEN         = 32;
  localparam int IDX_W        = 5;
  localparam int SEL_W        = 8;
  localparam int IMM_W        = 16;
  localparam int OPC_W        = 6;
  localparam int OPC_LSB      = 0;
  localparam int A_LSB        = 27;
  localparam int B_LSB        = 22;
  localparam int C_LSB        = 17;
  localparam int IMM_LSB      = 6;
  localparam int READRA_BIT   = 16;
  localparam int READRB_BIT   = 15;
  localparam int WRITERC_BIT  = 14;
  localparam int SEL_LSB      = 6;
  localparam logic [OPC_W-1:0] OPC_CMPNEI = 6'h18;
  localparam logic [OPC_W-1:0] OPC_CUSTOM = 6'h32;
  localparam logic [XLEN-1:0]  WORD_ZERO  = 32'h0000_0000;
  localparam logic [XLEN-1:0]  WORD_ONE   = 32'h0000_0001;
  localparam logic [IDX_W-1:0] IDX_ZERO   = 5'h00;
  localparam logic [SEL_W-1:0] SEL_ZERO   = 8'h00;
  typedef enum logic [1:0] {
    CND_IDLE,
    CND_WAIT
  } cnd_state_t;
endpackage

/* rtl/cnd_dec_if.sv */
`timescale 1ns/1ps
interface cnd_dec_if;
  import cnd_pkg::*;
  logic [XLEN-1:0]  instr;
  logic             is_cmpnei;
  logic             is_custom;
  logic [IDX_W-1:0] idx_a;
  logic [IDX_W-1:0] idx_b;
  logic [IDX_W-1:0] idx_c;
  logic [XLEN-1:0]  imm_ext;
  logic [SEL_W-1:0] sel;
  logic             read_a;
  logic             read_b;
  logic             write_c;
  modport dec (input instr, output is_cmpnei, is_custom, idx_a, idx_b, idx_c, imm_ext, sel, read_a, read_b, write_c);
  modport use_side (output instr, input is_cmpnei, is_custom, idx_a, idx_b, idx_c, imm_ext, sel, read_a, read_b,
                    write_c);
endinterface

/* rtl/cnd_field_dec.sv */
`timescale 1ns/1ps
module cnd_field_dec (
  cnd_dec_if.dec d
);
  import cnd_pkg::*;
  wire [OPC_W-1:0] opc_w = d.instr[OPC_LSB +: OPC_W];
  wire [IMM_W-1:0] imm_w = d.instr[IMM_LSB +: IMM_W];
  assign d.is_cmpnei = (opc_w == OPC_CMPNEI); // [RULE8]
  assign d.is_custom = (opc_w == OPC_CUSTOM); // [RULE8]
  assign d.idx_a     = d.instr[A_LSB +: IDX_W];
  assign d.idx_b     = d.instr[B_LSB +: IDX_W];
  assign d.idx_c     = d.instr[C_LSB +: IDX_W];
  assign d.imm_ext   = {{(XLEN-IMM_W){imm_w[IMM_W-1]}}, imm_w}; // [RULE1]
  assign d.sel       = d.instr[SEL_LSB +: SEL_W]; // [RULE3]
  assign d.read_a    = d.instr[READRA_BIT]; // [RULE5]
  assign d.read_b    = d.instr[READRB_BIT]; // [RULE5]
  assign d.write_c   = d.instr[WRITERC_BIT]; // [RULE4]
endmodule

/* rtl/cnd_exec.sv */
`timescale 1ns/1ps
module cnd_exec (
  input  wire logic                  clk_i,
  input  wire logic                  sys_rst_i,
  input  wire logic                  instr_valid_i,
  input  wire logic [cnd_pkg::XLEN-1:0]  instr_i,
  input  wire logic [cnd_pkg::XLEN-1:0]  src_one_val_i,
  input  wire logic [cnd_pkg::XLEN-1:0]  src_two_val_i,
  input  wire logic                  ci_done_i,
  input  wire logic [cnd_pkg::XLEN-1:0]  ci_result_i,
  output logic                       busy_o,
  output logic                       ci_start_o,
  output logic [cnd_pkg::SEL_W-1:0]  ci_sel_o,
  output logic [cnd_pkg::XLEN-1:0]   ci_dataa_o,
  output logic [cnd_pkg::XLEN-1:0]   ci_datab_o,
  output logic [cnd_pkg::IDX_W-1:0]  ci_a_o,
  output logic [cnd_pkg::IDX_W-1:0]  ci_b_o,
  output logic [cnd_pkg::IDX_W-1:0]  ci_c_o,
  output logic                       ci_readra_o,
  output logic                       ci_readrb_o,
  output logic                       ci_writerc_o,
  output logic                       gpr_we_o,
  output logic [cnd_pkg::IDX_W-1:0]  gpr_waddr_o,
  output logic [cnd_pkg::XLEN-1:0]   gpr_wdata_o
);
  import cnd_pkg::*;

  cnd_dec_if dif ();
  assign dif.instr = instr_i;
  cnd_field_dec u_dec (
    .d (dif)
  );

  cnd_state_t       state_r;
  cnd_state_t       state_nxt;
  logic             wrc_r;
  logic [IDX_W-1:0] c_r;

  wire take_w      = instr_valid_i && (state_r == CND_IDLE);
  wire do_cmp_w    = take_w && dif.is_cmpnei;
  wire do_ci_w     = take_w && dif.is_custom;
  wire ne_w        = (src_one_val_i != dif.imm_ext); // [RULE1]
  // General-register operand only when its read flag is set; else zero
  wire [XLEN-1:0] opa_w = dif.read_a ? src_one_val_i : WORD_ZERO; // [RULE5] [RULE6]
  wire [XLEN-1:0] opb_w = dif.read_b ? src_two_val_i : WORD_ZERO; // [RULE5] [RULE6]
  wire ci_fin_w    = (state_r == CND_WAIT) && ci_done_i;
  wire ci_wr_w     = ci_fin_w && wrc_r; // [RULE4]

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      CND_IDLE: begin
        if (do_ci_w) begin
          state_nxt = CND_WAIT;
        end
      end
      CND_WAIT: begin
        if (ci_done_i) begin
          state_nxt = CND_IDLE;
        end
      end
      default: begin
        state_nxt = CND_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_r <= CND_IDLE;
      wrc_r   <= 1'b0;
      c_r     <= IDX_ZERO;
    end else begin
      state_r <= state_nxt;
      if (do_ci_w) begin
        wrc_r <= dif.write_c;
        c_r   <= dif.idx_c;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ci_start_o   <= 1'b0;
      ci_sel_o     <= SEL_ZERO;
      ci_dataa_o   <= WORD_ZERO;
      ci_datab_o   <= WORD_ZERO;
      ci_a_o       <= IDX_ZERO;
      ci_b_o       <= IDX_ZERO;
      ci_c_o       <= IDX_ZERO;
      ci_readra_o  <= 1'b0;
      ci_readrb_o  <= 1'b0;
      ci_writerc_o <= 1'b0;
    end else begin
      ci_start_o <= do_ci_w;
      if (do_ci_w) begin
        ci_sel_o     <= dif.sel; // [RULE3]
        ci_dataa_o   <= opa_w; // [RULE7]
        ci_datab_o   <= opb_w; // [RULE7]
        ci_a_o       <= dif.idx_a; // [RULE7]
        ci_b_o       <= dif.idx_b; // [RULE7]
        ci_c_o       <= dif.idx_c; // [RULE7]
        ci_readra_o  <= dif.read_a; // [RULE6]
        ci_readrb_o  <= dif.read_b; // [RULE6]
        ci_writerc_o <= dif.write_c; // [RULE6]
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      busy_o      <= 1'b0;
      gpr_we_o    <= 1'b0;
      gpr_waddr_o <= IDX_ZERO;
      gpr_wdata_o <= WORD_ZERO;
    end else begin
      busy_o   <= (state_nxt == CND_WAIT);
      gpr_we_o <= do_cmp_w || ci_wr_w;
      if (do_cmp_w) begin
        gpr_waddr_o <= dif.idx_b;
        gpr_wdata_o <= ne_w ? WORD_ONE : WORD_ZERO; // [RULE2]
      end else if (ci_wr_w) begin
        gpr_waddr_o <= c_r; // [RULE4]
        gpr_wdata_o <= ci_result_i;
      end
    end
  end
endmodule

/* tb/cnd_properties.sv */
`timescale 1ns/1ps
module cnd_props import cnd_pkg::*; (
  input logic clk_i, sys_rst_i, instr_valid_i, busy_o, ci_start_o, ci_readra_o, ci_writerc_o, ci_done_i, gpr_we_o,
  input logic ci_readrb_o,
  input logic [31:0] instr_i, src_one_val_i, ci_dataa_o, ci_result_i, gpr_wdata_o, src_two_val_i, ci_datab_o,
  input logic [7:0] ci_sel_o,
  input logic [4:0] gpr_waddr_o, ci_a_o, ci_b_o, ci_c_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  wire tk = instr_valid_i && !busy_o;
  wire isc = tk && instr_i[5:0] == OPC_CMPNEI;
  wire isx = tk && instr_i[5:0] == OPC_CUSTOM;
  wire fin = busy_o && ci_done_i;
  wire ne = src_one_val_i != {{16{instr_i[21]}}, instr_i[21:6]};
  property p_cw; isc |=> gpr_we_o && gpr_waddr_o == $past(instr_i[26:22]); endproperty
  property p_cv; isc |=> gpr_wdata_o == {31'h0, $past(ne)}; endproperty
  property p_cs; isx |=> ci_start_o && busy_o && ci_sel_o == $past(instr_i[13:6]); endproperty
  property p_rd; ci_start_o |-> ci_readra_o == $past(instr_i[16])
    && ci_dataa_o == (ci_readra_o ? $past(src_one_val_i) : 32'h0); endproperty
  property p_ix; ci_start_o |-> ci_a_o == $past(instr_i[31:27]) && ci_b_o == $past(instr_i[26:22])
    && ci_c_o == $past(instr_i[21:17]) && ci_readrb_o == $past(instr_i[15])
    && ci_datab_o == (ci_readrb_o ? $past(src_two_val_i) : 32'h0); endproperty
  property p_wc; fin |=> !busy_o && gpr_we_o == ci_writerc_o; endproperty
  property p_wd; fin && ci_writerc_o |=> gpr_wdata_o == $past(ci_result_i); endproperty
  property p_hd; busy_o && !ci_done_i |=> busy_o && !gpr_we_o; endproperty
  property p_ig; tk && !isc && !isx |=> !gpr_we_o && !ci_start_o; endproperty
  a_cw: assert property (p_cw) else $error("cmp index");
  a_cv: assert property (p_cv) else $error("cmp value");
  a_cs: assert property (p_cs) else $error("launch");
  a_rd: assert property (p_rd) else $error("operand");
  a_ix: assert property (p_ix) else $error("indices");
  a_wc: assert property (p_wc) else $error("route");
  a_wd: assert property (p_wd) else $error("result");
  a_hd: assert property (p_hd) else $error("hold");
  a_ig: assert property (p_ig) else $error("other op");
  cover property (isc);
  cover property (isx);
  cover property (fin && ci_writerc_o);
endmodule
bind cnd_exec cnd_props i_props (.*);

/* tb/cnd_ci_model.sv */
`timescale 1ns/1ps
module cnd_ci_model (
  input logic clk_i, ci_start_o,
  input logic [7:0] ci_sel_o,
  input logic [31:0] ci_dataa_o, ci_datab_o,
  input int dly,
  output logic ci_done_i = 1'b0,
  output logic [31:0] ci_result_i = 32'h0
);
  int n = -1;
  logic [31:0] r;
  always @(posedge clk_i) begin
    ci_done_i <= 1'b0;
    ci_result_i <= ~ci_result_i;
    if (ci_start_o) begin
      r = ci_dataa_o ^ ci_datab_o ^ ci_sel_o;
      n = dly;
    end else if (n > 0) begin
      n--;
    end else if (n == 0) begin
      ci_done_i <= 1'b1;
      ci_result_i <= r;
      n = -1;
    end
  end
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import cnd_pkg::*;
  logic clk_i = 0, sys_rst_i = 1, instr_valid_i = 0, ci_done_i, busy_o, ci_start_o, ci_readra_o, ci_readrb_o;
  logic ci_writerc_o, gpr_we_o;
  logic [31:0] instr_i = 0, src_one_val_i = 0, src_two_val_i = 0, ci_result_i, ci_dataa_o, ci_datab_o, gpr_wdata_o;
  logic [31:0] s1, s2, w;
  logic [7:0] ci_sel_o;
  logic [4:0] ci_a_o, ci_b_o, ci_c_o, gpr_waddr_o;
  logic [36:0] q[$];
  int seed = 32'hd31a, dly = 0, checks = 0, n_errors = 0;
  cnd_exec i_dut (.*);
  cnd_ci_model i_ci (.*);
  always #50 clk_i = ~clk_i;
  task automatic cmp(string nm, logic [36:0] x, y);
    checks++;
    if (x !== y) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", nm, x, y);
    end
  endtask
  task stop_test;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic go(logic push, logic [36:0] ex);
    @(posedge clk_i);
    instr_valid_i <= 1;
    instr_i <= w;
    src_one_val_i <= s1;
    src_two_val_i <= s2;
    if (push) q.push_back(ex);
  endtask
  always @(negedge clk_i) if (gpr_we_o === 1'b1) begin
    cmp("gpr write", q.size() ? q.pop_front() : 37'bx, {gpr_waddr_o, gpr_wdata_o});
  end
  initial begin
    #100000;
    n_errors++;
    stop_test;
  end
  initial begin
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 0;
    for (int i = 0; i < 17; i++) begin
      w = $random(seed);
      w[5:0] = i < 16 ? OPC_CMPNEI : 6'h3a;
      s1 = i[0] ? {{16{w[21]}}, w[21:6]} : $random(seed);
      s2 = $random(seed);
      go(i < 16, {w[26:22], 31'h0, s1 != {{16{w[21]}}, w[21:6]}});
    end
    $display("compare test done");
    for (int i = 0; i < 8; i++) begin
      w = $random(seed);
      w[16:14] = i[2:0];
      w[5:0] = OPC_CUSTOM;
      {s1, s2} = {$random(seed), $random(seed)};
      dly = i % 3 * 2;
      go(w[14], {w[21:17], (w[16] ? s1 : 32'h0) ^ (w[15] ? s2 : 32'h0) ^ w[13:6]});
      @(posedge clk_i);
      instr_valid_i <= 0;
      for (int k = 0; k < 20 && (k < 2 || busy_o); k++) @(posedge clk_i);
    end
    $display("custom test done");
    repeat (3) @(posedge clk_i);
    cmp("queue left", 37'h0, 37'(q.size()));
    stop_test;
  end
endmodule
